//--- hbo_defs.svh
// constants for the host bus ownership control block
`ifndef HBO_DEFS_SVH
`define HBO_DEFS_SVH
`define HBO_NUM_PEERS 6
`define HBO_ID_W 3
`define HBO_ID_NONE 3'h0
`define HBO_CNT_W 4
`define HBO_WAIT_CYCLES 4'h2
`endif

//--- hbo_pkg.sv
// types for the host bus ownership control block
`default_nettype none
package hbo_pkg;
	typedef enum logic [1:0] {
		HBO_IDLE = 2'b00,
		HBO_MASTER = 2'b01,
		HBO_GRANTED = 2'b10
	} hbo_own_t;
	typedef struct packed {
		logic float_n;
		logic ready_o;
		logic ready_oe;
		logic grant_o;
		logic grant_oe;
		logic stall;
		logic [5:0] preq_o;
		logic [5:0] preq_oe;
	} hbo_pins_t;
	typedef struct packed {
		hbo_own_t own;
		logic [3:0] wait_cnt;
		hbo_pins_t pins;
	} hbo_state_t;
endpackage : hbo_pkg
`default_nettype wire

//--- hbo_ctrl.sv
// host bus ownership control: host grant, peer requests, suspend, ready
//
// Overview of operation
// - suspend input low floats address, data, selects and strobes next cycle.
// - core external access while suspended stalls until suspend released.
// - host request makes the current master yield and assert grant.
// - yielding master puts address, data, select, strobe outputs high-Z.
// - host request outranks every peer processor bus request.
// - grant stays low until the host drops its request.
// - only the bus master, or the master that yielded to the host, drives grant; others only monitor it.
// - ready driven low for wait states on host internal accesses.
// - ready is open-drain by default; active-drive bit switches it.
// - ready driven only while select and host request both asserted.
// - drive only own peer request line; monitor all the others.
// - identity input chooses which of six peer lines is ours.
`timescale 1ns/1ns
`default_nettype none
`include "hbo_defs.svh"
module hbo_ctrl #(
	parameter int NUM_PEERS = `HBO_NUM_PEERS,
	parameter logic [3:0] WAIT_CYCLES = `HBO_WAIT_CYCLES
) (
	input wire logic clock_i,               // processor clock
	input wire logic reset_i,               // sync reset, high
	input wire logic suspend_bus_float_in_n_i, // suspend, low active
	input wire logic host_bus_request_in_n_i,  // host request, low
	input wire logic device_select_n_i,     // host select, low
	input wire logic host_bus_grant_n_i,    // grant pin level seen
	input wire logic [2:0] processor_identity_in_i, // identity
	input wire logic [5:0] peer_bus_request_lines_n_i, // peer lines
	input wire logic ready_active_drive_bit_i, // control reg bit
	input wire logic core_ext_req_i,        // core wants external bus
	input wire logic host_access_busy_i,    // host internal access busy
	output logic bus_drive_en_o,            // addr/data/strobe enable
	output logic core_stall_o,              // stall core access
	output logic host_bus_grant_n_o,        // grant pin out
	output logic host_bus_grant_oe_o,       // grant pin enable
	output logic host_ready_out_o,          // ready pin out
	output logic host_ready_out_oe_o,       // ready pin enable
	output logic [5:0] peer_bus_request_lines_n_o, // peer pins out
	output logic [5:0] peer_bus_request_lines_oe_o // peer enables
);
	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	function automatic logic [5:0] id_onehot(input logic [2:0] id);
		logic [5:0] v;
		v = 6'h00;
		if (id != `HBO_ID_NONE && id <= 3'h6) begin
			v[id - 3'h1] = 1'b1;
		end
		return v;
	endfunction : id_onehot

	hbo_pkg::hbo_state_t s_q;
	hbo_pkg::hbo_state_t s_d;
	logic [5:0] own_line;
	logic host_req;
	logic suspended;
	logic others_req;
	logic lower_req;
	logic host_acc;

	assign own_line = id_onehot(processor_identity_in_i);
	assign host_req = ~host_bus_request_in_n_i;
	assign suspended = ~suspend_bus_float_in_n_i;
	assign host_acc = ~device_select_n_i & host_req;

	// monitor every line but ours
	always_comb begin
		others_req = 1'b0;
		lower_req = 1'b0;
		for (int i = 0; i < NUM_PEERS; i++) begin
			if (!own_line[i] && !peer_bus_request_lines_n_i[i]) begin
				others_req = 1'b1;
				if (own_line > (6'h01 << i)) begin
					lower_req = 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		unique case (s_q.own)
			hbo_pkg::HBO_IDLE: begin
				// host outranks peers; lowest id wins among peers
				// a low grant wire means the host owns the bus
				if (core_ext_req_i && !host_req && !lower_req &&
				    host_bus_grant_n_i && own_line != 6'h00) begin
					s_d.own = hbo_pkg::HBO_MASTER;
				end
			end
			hbo_pkg::HBO_MASTER: begin
				if (host_req) begin
					s_d.own = hbo_pkg::HBO_GRANTED;
				end else if (!core_ext_req_i && others_req) begin
					s_d.own = hbo_pkg::HBO_IDLE;
				end
			end
			hbo_pkg::HBO_GRANTED: begin
				// grant held until host releases
				if (!host_req) begin
					s_d.own = hbo_pkg::HBO_MASTER;
				end
			end
			default: s_d.own = hbo_pkg::HBO_IDLE;
		endcase

		// float on suspend takes effect the following cycle
		s_d.pins.float_n = (s_d.own == hbo_pkg::HBO_MASTER) && !suspended;
		s_d.pins.stall = core_ext_req_i &&
			(suspended || s_d.own != hbo_pkg::HBO_MASTER);

		// only the master, or the master that yielded to the host, drives grant
		s_d.pins.grant_oe = (s_d.own != hbo_pkg::HBO_IDLE);
		s_d.pins.grant_o = (s_d.own != hbo_pkg::HBO_GRANTED);

		// own request line only
		s_d.pins.preq_oe = own_line;
		s_d.pins.preq_o = ~(own_line & {6{core_ext_req_i}});

		// ready: wait states during host access
		if (host_acc && host_access_busy_i) begin
			s_d.wait_cnt = WAIT_CYCLES;
		end else if (s_q.wait_cnt != 4'h0) begin
			s_d.wait_cnt = s_q.wait_cnt - 4'h1;
		end
		s_d.pins.ready_o = !(host_acc &&
			(host_access_busy_i || s_q.wait_cnt != 4'h0));
		// open-drain unless active drive set
		// driven only while select and request held
		s_d.pins.ready_oe = host_acc &&
			(ready_active_drive_bit_i || !s_d.pins.ready_o);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_q <= '{own: hbo_pkg::HBO_IDLE, wait_cnt: 4'h0,
				pins: '{float_n: 1'b0, ready_o: 1'b1, ready_oe: 1'b0,
				grant_o: 1'b1, grant_oe: 1'b0, stall: 1'b0,
				preq_o: 6'h3f, preq_oe: 6'h00}};
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_drive_en_o = s_q.pins.float_n;
	assign core_stall_o = s_q.pins.stall;
	assign host_bus_grant_n_o = s_q.pins.grant_o;
	assign host_bus_grant_oe_o = s_q.pins.grant_oe;
	assign host_ready_out_o = s_q.pins.ready_o;
	assign host_ready_out_oe_o = s_q.pins.ready_oe;
	assign peer_bus_request_lines_n_o = s_q.pins.preq_o;
	assign peer_bus_request_lines_oe_o = s_q.pins.preq_oe;
endmodule : hbo_ctrl
`default_nettype wire

//--- hbo_ctrl_props.sv
// assertions on the host bus ownership control ports
`timescale 1ns/1ns
`default_nettype none
module hbo_ctrl_props (
	input wire logic clock_i, reset_i, suspend_bus_float_in_n_i,
	input wire logic host_bus_request_in_n_i, device_select_n_i,
	input wire logic ready_active_drive_bit_i, core_ext_req_i,
	input wire logic bus_drive_en_o, core_stall_o, host_bus_grant_n_o,
	input wire logic host_bus_grant_oe_o, host_ready_out_o,
	input wire logic host_ready_out_oe_o,
	input wire logic [2:0] processor_identity_in_i,
	input wire logic [5:0] peer_bus_request_lines_oe_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	logic hreq, sel_q;
	logic [5:0] own_q;
	assign hreq = !host_bus_request_in_n_i;
	// ids outside 1..6 own no line
	always_ff @(posedge clock_i) begin
		sel_q <= hreq && !device_select_n_i;
		own_q <= (processor_identity_in_i inside {[1:6]}) ?
			6'h01 << (processor_identity_in_i - 3'h1) : 6'h00;
	end
	chk_float_next: assert property (!suspend_bus_float_in_n_i |=>
		!bus_drive_en_o) else $error("bus driven after suspend");
	chk_stall_susp: assert property ((!suspend_bus_float_in_n_i &&
		core_ext_req_i) |=> core_stall_o) else $error("no stall");
	chk_grant_yield: assert property ((bus_drive_en_o && hreq) |=>
		!host_bus_grant_n_o && host_bus_grant_oe_o) else $error("no grant");
	chk_grant_float: assert property (host_bus_grant_oe_o &&
		!host_bus_grant_n_o |-> !bus_drive_en_o) else $error("bus not floated");
	chk_host_first: assert property (hreq && !bus_drive_en_o |=>
		!bus_drive_en_o) else $error("mastered over host request");
	chk_grant_hold: assert property (!host_bus_grant_n_o && hreq |=>
		!host_bus_grant_n_o) else $error("grant dropped early");
	chk_ready_od: assert property (host_ready_out_oe_o &&
		!$past(ready_active_drive_bit_i) |-> !host_ready_out_o)
		else $error("ready driven high");
	chk_ready_sel: assert property (!host_ready_out_o |-> sel_q)
		else $error("ready low without select");
	chk_own_line: assert property ((peer_bus_request_lines_oe_o &
		~own_q) == 6'h00) else $error("foreign request line driven");
	cover property (!host_bus_grant_n_o);
	cover property (core_stall_o);
	cover property (!host_ready_out_o);
endmodule : hbo_ctrl_props
bind hbo_ctrl hbo_ctrl_props hbo_ctrl_props_inst (.*);
`default_nettype wire

//--- hbo_host_model.sv
// host processor model: requests the bus, selects once granted
`timescale 1ns/1ns
`default_nettype none
module hbo_host_model (
	input wire logic clock_i, // processor clock
	input wire logic want_i, // bench wants the bus
	input wire logic grant_n_i, // grant wire level
	output logic hreq_n_o, // host request
	output logic cs_n_o // device select
);
	initial begin
		hreq_n_o = 1'b1;
		cs_n_o = 1'b1;
	end
	always @(negedge clock_i) begin
		hreq_n_o <= !want_i;
		cs_n_o <= !(want_i && !grant_n_i);
	end
endmodule : hbo_host_model
`default_nettype wire

//--- tb_top.sv
// testbench for the host bus ownership control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clock_i = 0, reset_i = 1, suspend_bus_float_in_n_i = 1, want = 0;
	logic ready_active_drive_bit_i = 0, core_ext_req_i = 0;
	logic host_access_busy_i = 0, host_bus_request_in_n_i, device_select_n_i;
	logic [2:0] processor_identity_in_i = 3'h2;
	logic [5:0] peer_bus_request_lines_n_i = 6'h3f;
	logic host_bus_grant_n_i, bus_drive_en_o, core_stall_o, host_bus_grant_n_o;
	logic host_bus_grant_oe_o, host_ready_out_o, host_ready_out_oe_o;
	logic [5:0] peer_bus_request_lines_n_o, peer_bus_request_lines_oe_o;
	int errors = 0, checked = 0;
	// grant wire pulled up when released
	assign host_bus_grant_n_i = !host_bus_grant_oe_o || host_bus_grant_n_o;
	always #50 clock_i = !clock_i;
	hbo_ctrl hbo_ctrl_inst (.*);
	hbo_host_model hbo_host_model_inst (.clock_i, .want_i(want),
		.grant_n_i(host_bus_grant_n_i), .hreq_n_o(host_bus_request_in_n_i),
		.cs_n_o(device_select_n_i));
	task chk(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(negedge clock_i);
	endtask : step
	task conclude;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	// ----
	// scenarios
	// ----
	task t_master;
		core_ext_req_i <= 1;
		step(4);
		chk(bus_drive_en_o, 1);
		chk(peer_bus_request_lines_oe_o & 6'h3d, 6'h00);
		chk(peer_bus_request_lines_n_o, 6'h3d);
		$display("test master done");
	endtask : t_master
	task t_host;
		want <= 1;
		step(3);
		chk({host_bus_grant_n_o, host_bus_grant_oe_o, bus_drive_en_o}, 3'h2);
		peer_bus_request_lines_n_i <= 6'h3e;
		step(4);
		chk({host_bus_grant_n_o, bus_drive_en_o}, 2'h0);
		peer_bus_request_lines_n_i <= 6'h3f;
		want <= 0;
		step(4);
		chk({host_bus_grant_n_o, bus_drive_en_o}, 2'h3);
		$display("test host done");
	endtask : t_host
	task t_suspend;
		suspend_bus_float_in_n_i <= 0;
		step(1);
		chk({bus_drive_en_o, core_stall_o}, 2'h1);
		suspend_bus_float_in_n_i <= 1;
		step(2);
		chk({bus_drive_en_o, core_stall_o}, 2'h2);
		$display("test suspend done");
	endtask : t_suspend
	task t_ready;
		host_access_busy_i <= 1;
		want <= 1;
		step(5);
		chk({host_ready_out_o, host_ready_out_oe_o}, 2'h1);
		host_access_busy_i <= 0;
		step(5);
		chk({host_ready_out_o, host_ready_out_oe_o}, 2'h2);
		ready_active_drive_bit_i <= 1;
		step(2);
		chk({host_ready_out_o, host_ready_out_oe_o}, 2'h3);
		want <= 0;
		ready_active_drive_bit_i <= 0;
		host_access_busy_i <= 1;
		step(4);
		chk({host_ready_out_o, host_ready_out_oe_o}, 2'h2);
		host_access_busy_i <= 0;
		$display("test ready done");
	endtask : t_ready
	initial begin
		#500000;
		errors++;
		conclude();
	end
	initial begin
		step(8);
		chk({host_bus_grant_oe_o, host_ready_out_oe_o, bus_drive_en_o}, 3'h0);
		reset_i <= 0;
		t_master();
		t_host();
		t_suspend();
		t_ready();
		conclude();
	end
endmodule : tb_top
`default_nettype wire
